// *** rtl/gcsm_defines.svh ***
`ifndef GCSM_DEFINES_SVH
`define GCSM_DEFINES_SVH

// Control register field positions
`define GCSM_BIT_IRQ_EN 7
`define GCSM_BIT_FLAG 6
`define GCSM_BIT_MON_ON 5
`define GCSM_BIT_SRC_SEL 4
`define GCSM_BIT_INT_ON 3
`define GCSM_BIT_INT_STABLE 2
`define GCSM_BIT_EXT_ON 1
`define GCSM_BIT_EXT_STABLE 0

// Reset value of the writable control bits: internal generator on, internal selected
`define GCSM_CTRL_RESET 8'h08

// Oscillator control limits and reset values
`define GCSM_DIV_MAX 4'h9
`define GCSM_DIV_RESET 4'h0
`define GCSM_STAGE_RESET 8'h80
`define GCSM_STAGE_MAX 8'hFF

`endif

// *** rtl/gcsm_pkg.sv ***
package gcsm_pkg;

    // Control register image
    typedef logic [7:0] gcsm_ctrl_t;

    // Oscillator divider and stage control words
    typedef logic [3:0] gcsm_div_t;
    typedef logic [7:0] gcsm_stage_t;

    // Step request from the loop filter
    typedef enum logic [1:0] {
        GCSM_STEP_NONE,
        GCSM_STEP_UP,
        GCSM_STEP_DOWN
    } gcsm_step_t;

endpackage : gcsm_pkg

// *** rtl/gcsm_clk_switch.sv ***
`timescale 1ns/10ps

// Glitch-free two-way clock switch working on sampled clock levels.
// Each side has a two-stage select chain advanced only on that side's falling
// edge, so its gate only opens or closes while that clock is low.
module gcsm_clk_switch (
    input wire logic clk,
    input wire logic srst,
    input wire logic int_lvl,
    input wire logic ext_lvl,
    input wire logic sel_ext,
    input wire logic force_int_off,
    input wire logic force_ext_off,
    output logic clk_out,
    output logic int_active,
    output logic ext_active
);
    import gcsm_pkg::*;

    logic int_prev_q;
    logic ext_prev_q;
    logic int_s1_q;
    logic int_s2_q;
    logic ext_s1_q;
    logic ext_s2_q;
    logic clk_out_q;
    logic int_fall;
    logic ext_fall;

    // **********************************************************
    // Edge detection
    // **********************************************************

    // Remember the last sampled level of each source
    always_ff @(posedge clk) begin
        if (srst) begin
            int_prev_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else begin
            int_prev_q <= int_lvl;
            ext_prev_q <= ext_lvl;
        end
    end

    assign int_fall = int_prev_q & ~int_lvl;
    assign ext_fall = ext_prev_q & ~ext_lvl;

    // **********************************************************
    // Select chains
    // **********************************************************

    // Internal side: resets selected; old clock runs on through both stages
    always_ff @(posedge clk) begin
        if (srst) begin
            int_s1_q <= 1'b1;
            int_s2_q <= 1'b1;
        end else if (force_int_off) begin
            // A dead source gives no edges, so its chain cannot step itself
            int_s1_q <= 1'b0;
            int_s2_q <= 1'b0;
        end else if (int_fall) begin
            int_s1_q <= ~sel_ext & ~ext_s2_q;
            int_s2_q <= int_s1_q;
        end
    end

    // External side: opens only after the internal gate has closed
    always_ff @(posedge clk) begin
        if (srst) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
        end else if (force_ext_off) begin
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
        end else if (ext_fall) begin
            ext_s1_q <= sel_ext & ~int_s2_q;
            ext_s2_q <= ext_s1_q;
        end
    end

    // **********************************************************
    // Output gating
    // **********************************************************

    // Gates only change while their clock is low, so no runt pulse appears
    always_ff @(posedge clk) begin
        if (srst) begin
            clk_out_q <= 1'b0;
        end else begin
            clk_out_q <= (int_s2_q & int_lvl) | (ext_s2_q & ext_lvl);
        end
    end

    assign clk_out = clk_out_q;
    assign int_active = int_s2_q;
    assign ext_active = ext_s2_q;

endmodule : gcsm_clk_switch

// *** rtl/gcsm_top.sv ***
`timescale 1ns/10ps
`include "gcsm_defines.svh"

// Summary of operation
// - Old clock keeps driving the output one to two of its cycles after select change.
// - Output then held low one to two cycles of the new clock.
// - Afterwards output follows the new clock with no glitch or runt.
// - Reset selects the internal oscillator clock.
// - Monitor on plus dead source forces the live clock, dead side deselected.
// - Forced live clock becomes selected one to two of its cycles later.
// - Output switch follows source select; timebase switch follows external enable.
// - Source select write takes effect only if target generator is on and stable.
// - Internal enable clears only once the external source is selected.
// - Monitor enable sets only with both enables and both stable flags.
// - Monitor interrupt enable sets only while monitor enable is already set.
// - Monitor flag clears by read seeing it set then writing zero.
// - Monitor enable stays set when a stable flag later drops.
// - On inactivity both clocks move to live source; select bit follows.
// - Oscillator period changes only by single steps of divider and stage controls.
// - Source select set picks external clock, cleared picks internal.
// - Dead indicators come from detectors missing edges two reference low phases.
module gcsm_top (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic INT_OSC_CLK,
    input wire logic EXT_OSC_CLK,
    input wire logic INT_CLK_DEAD,
    input wire logic EXT_CLK_DEAD,
    input wire logic INT_GEN_STABLE,
    input wire logic EXT_GEN_STABLE,
    input wire logic WR_EN,
    input wire gcsm_pkg::gcsm_ctrl_t WR_DATA,
    input wire logic RD_EN,
    output gcsm_pkg::gcsm_ctrl_t RD_DATA,
    input wire gcsm_pkg::gcsm_step_t LOOP_FILTER_STEP,
    output gcsm_pkg::gcsm_div_t OSC_DIV_CTRL,
    output gcsm_pkg::gcsm_stage_t OSC_STAGE_CTRL,
    output logic OSC_OUT_CLK,
    output logic TIMEBASE_CLK,
    output logic MONITOR_IRQ
);
    import gcsm_pkg::*;

    logic [2:0] int_sync_q;
    logic [2:0] ext_sync_q;
    logic int_lvl_q;
    logic ext_lvl_q;
    logic irq_en_q;
    logic flag_q;
    logic mon_on_q;
    logic src_sel_q;
    logic int_on_q;
    logic ext_on_q;
    logic flag_read_q;
    gcsm_ctrl_t rd_data_q;
    gcsm_ctrl_t ctrl_img;
    gcsm_div_t div_q;
    gcsm_stage_t stage_q;
    logic fail_int;
    logic fail_ext;
    logic osc_force_int_off;
    logic osc_force_ext_off;
    logic tb_sel_ext;

    // Reset image of the writable bits; single bits are picked from it below
    localparam gcsm_ctrl_t CTRL_RST = `GCSM_CTRL_RESET;

    // **********************************************************
    // Helper functions
    // **********************************************************

    // A generator is trusted only when switched on and reported stable
    function automatic logic gen_ready(input logic on, input logic stable);
        return on & stable;
    endfunction : gen_ready

    // Failover needs a dead source and a live one to move to
    function automatic logic only_dead(input logic mon, input logic dead, input logic other);
        return mon & dead & ~other;
    endfunction : only_dead

    // **********************************************************
    // Pin synchronisers
    // **********************************************************

    // Three flops per clock pin; the level moves only when stages two and three agree
    always_ff @(posedge CLK) begin
        if (SRST) begin
            int_sync_q <= 3'h0;
            ext_sync_q <= 3'h0;
            int_lvl_q <= 1'b0;
            ext_lvl_q <= 1'b0;
        end else begin
            int_sync_q <= {int_sync_q[1:0], INT_OSC_CLK};
            ext_sync_q <= {ext_sync_q[1:0], EXT_OSC_CLK};
            if (int_sync_q[1] == int_sync_q[2]) begin
                int_lvl_q <= int_sync_q[2];
            end
            if (ext_sync_q[1] == ext_sync_q[2]) begin
                ext_lvl_q <= ext_sync_q[2];
            end
        end
    end

    // **********************************************************
    // Failover decode
    // **********************************************************

    // With both dead there is nothing to fail over to, so neither is forced
    assign fail_int = only_dead(mon_on_q, INT_CLK_DEAD, EXT_CLK_DEAD);
    assign fail_ext = only_dead(mon_on_q, EXT_CLK_DEAD, INT_CLK_DEAD);
    assign osc_force_int_off = fail_int;
    assign osc_force_ext_off = fail_ext;
    // Timebase follows the external enable unless a failover overrides it
    assign tb_sel_ext = fail_int | (ext_on_q & ~fail_ext);

    // **********************************************************
    // Control register
    // **********************************************************

    // Register image as software reads it
    always_comb begin
        ctrl_img = 8'h00;
        ctrl_img[`GCSM_BIT_IRQ_EN] = irq_en_q;
        ctrl_img[`GCSM_BIT_FLAG] = flag_q;
        ctrl_img[`GCSM_BIT_MON_ON] = mon_on_q;
        ctrl_img[`GCSM_BIT_SRC_SEL] = src_sel_q;
        ctrl_img[`GCSM_BIT_INT_ON] = int_on_q;
        ctrl_img[`GCSM_BIT_INT_STABLE] = INT_GEN_STABLE;
        ctrl_img[`GCSM_BIT_EXT_ON] = ext_on_q;
        ctrl_img[`GCSM_BIT_EXT_STABLE] = EXT_GEN_STABLE;
    end

    // Source select: write needs a ready target, failover overrides writes
    always_ff @(posedge CLK) begin
        if (SRST) begin
            src_sel_q <= CTRL_RST[`GCSM_BIT_SRC_SEL];
        end else if (fail_int) begin
            src_sel_q <= 1'b1;
        end else if (fail_ext) begin
            src_sel_q <= 1'b0;
        end else if (WR_EN) begin
            if (WR_DATA[`GCSM_BIT_SRC_SEL] && gen_ready(ext_on_q, EXT_GEN_STABLE)) begin
                src_sel_q <= 1'b1;
            end else if (!WR_DATA[`GCSM_BIT_SRC_SEL] && gen_ready(int_on_q, INT_GEN_STABLE)) begin
                src_sel_q <= 1'b0;
            end
        end
    end

    // Generator enables: the selected source cannot be switched off under itself
    // Clearing the selected source would stop the output clock, so it is refused
    always_ff @(posedge CLK) begin
        if (SRST) begin
            int_on_q <= CTRL_RST[`GCSM_BIT_INT_ON];
            ext_on_q <= CTRL_RST[`GCSM_BIT_EXT_ON];
        end else if (WR_EN) begin
            if (WR_DATA[`GCSM_BIT_INT_ON] || src_sel_q) begin
                int_on_q <= WR_DATA[`GCSM_BIT_INT_ON];
            end
            if (WR_DATA[`GCSM_BIT_EXT_ON] || !src_sel_q) begin
                ext_on_q <= WR_DATA[`GCSM_BIT_EXT_ON];
            end
        end
    end

    // Monitor enable: gated on set, free to clear, holds through stable drops
    always_ff @(posedge CLK) begin
        if (SRST) begin
            mon_on_q <= 1'b0;
        end else if (WR_EN) begin
            if (!WR_DATA[`GCSM_BIT_MON_ON]) begin
                mon_on_q <= 1'b0;
            end else if (gen_ready(int_on_q, INT_GEN_STABLE)
                && gen_ready(ext_on_q, EXT_GEN_STABLE)) begin
                mon_on_q <= 1'b1;
            end
            // Otherwise the bit keeps its value, so a set bit survives
        end
    end

    // Monitor interrupt enable: only sets behind an already set monitor
    always_ff @(posedge CLK) begin
        if (SRST) begin
            irq_en_q <= 1'b0;
        end else if (WR_EN) begin
            if (!WR_DATA[`GCSM_BIT_IRQ_EN]) begin
                irq_en_q <= 1'b0;
            end else if (mon_on_q) begin
                irq_en_q <= 1'b1;
            end
        end
    end

    // Read of a set flag arms the clear; a write ends the sequence either way
    always_ff @(posedge CLK) begin
        if (SRST) begin
            flag_read_q <= 1'b0;
        end else if (WR_EN) begin
            flag_read_q <= 1'b0;
        end else if (RD_EN && flag_q) begin
            flag_read_q <= 1'b1;
        end
    end

    // Monitor flag: a new event beats a clear in the same cycle
    always_ff @(posedge CLK) begin
        if (SRST) begin
            flag_q <= 1'b0;
        end else if (mon_on_q && (INT_CLK_DEAD || EXT_CLK_DEAD)) begin
            flag_q <= 1'b1;
        end else if (WR_EN && flag_read_q && !WR_DATA[`GCSM_BIT_FLAG]) begin
            flag_q <= 1'b0;
        end
    end

    // Registered read data, one cycle after the read strobe
    always_ff @(posedge CLK) begin
        if (SRST) begin
            rd_data_q <= 8'h00;
        end else if (RD_EN) begin
            rd_data_q <= ctrl_img;
        end
    end

    // Interrupt is a level that drops as soon as flag or enable clears
    assign RD_DATA = rd_data_q;
    assign MONITOR_IRQ = flag_q & irq_en_q;

    // **********************************************************
    // Oscillator step control
    // **********************************************************

    // Stage steps by one; divider moves only on a stage carry or borrow
    always_ff @(posedge CLK) begin
        if (SRST) begin
            div_q <= `GCSM_DIV_RESET;
            stage_q <= `GCSM_STAGE_RESET;
        end else begin
            case (LOOP_FILTER_STEP)
                GCSM_STEP_UP: begin
                    if (stage_q != `GCSM_STAGE_MAX) begin
                        stage_q <= stage_q + 8'h01;
                    end else if (div_q < `GCSM_DIV_MAX) begin
                        stage_q <= 8'h00;
                        div_q <= div_q + 4'h1;
                    end
                end
                GCSM_STEP_DOWN: begin
                    if (stage_q != 8'h00) begin
                        stage_q <= stage_q - 8'h01;
                    end else if (div_q != 4'h0) begin
                        stage_q <= `GCSM_STAGE_MAX;
                        div_q <= div_q - 4'h1;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    assign OSC_DIV_CTRL = div_q;
    assign OSC_STAGE_CTRL = stage_q;

    // **********************************************************
    // Clock switches
    // **********************************************************

    // Oscillator output switch steered by the source select bit
    gcsm_clk_switch u_osc_switch (
        .clk(CLK),
        .srst(SRST),
        .int_lvl(int_lvl_q),
        .ext_lvl(ext_lvl_q),
        .sel_ext(src_sel_q),
        .force_int_off(osc_force_int_off),
        .force_ext_off(osc_force_ext_off),
        .clk_out(OSC_OUT_CLK),
        .int_active(),
        .ext_active()
    );

    // Timebase switch steered by the external enable
    gcsm_clk_switch u_tb_switch (
        .clk(CLK),
        .srst(SRST),
        .int_lvl(int_lvl_q),
        .ext_lvl(ext_lvl_q),
        .sel_ext(tb_sel_ext),
        .force_int_off(fail_int),
        .force_ext_off(fail_ext),
        .clk_out(TIMEBASE_CLK),
        .int_active(),
        .ext_active()
    );

endmodule : gcsm_top

// *** sim/gcsm_monitor.sv ***
`timescale 1ns/10ps

// ****************************************
// Port checker for the clock switch top
// ****************************************
module gcsm_chk (
    input wire logic CLK,
    input wire logic SRST,
    input wire logic RD_EN,
    input wire gcsm_pkg::gcsm_ctrl_t RD_DATA,
    input wire gcsm_pkg::gcsm_step_t LOOP_FILTER_STEP,
    input wire gcsm_pkg::gcsm_div_t OSC_DIV_CTRL,
    input wire gcsm_pkg::gcsm_stage_t OSC_STAGE_CTRL,
    input wire logic OSC_OUT_CLK,
    input wire logic TIMEBASE_CLK,
    input wire logic MONITOR_IRQ
);
    import gcsm_pkg::*;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);

    // Sampled oscillators stay high or low at least four cycles, so a shorter phase is a runt
    sequence s_out_hi; OSC_OUT_CLK [*4]; endsequence
    sequence s_out_lo; !OSC_OUT_CLK [*4]; endsequence
    sequence s_tb_hi; TIMEBASE_CLK [*4]; endsequence

    AST_RST_VALUES: assert property ($fell(SRST) |-> RD_DATA == 8'h00 &&
        OSC_DIV_CTRL == 4'h0 && OSC_STAGE_CTRL == 8'h80 && !MONITOR_IRQ)
        else $error("reset values wrong");
    AST_STEP_UP: assert property ((LOOP_FILTER_STEP == GCSM_STEP_UP &&
        OSC_STAGE_CTRL != 8'hFF) |=> OSC_STAGE_CTRL == $past(OSC_STAGE_CTRL) + 8'h01
        && $stable(OSC_DIV_CTRL)) else $error("stage up step wrong");
    AST_STEP_CARRY: assert property ((LOOP_FILTER_STEP == GCSM_STEP_UP &&
        OSC_STAGE_CTRL == 8'hFF && OSC_DIV_CTRL < 4'h9) |=> OSC_STAGE_CTRL == 8'h00
        && OSC_DIV_CTRL == $past(OSC_DIV_CTRL) + 4'h1) else $error("carry wrong");
    AST_STEP_BORROW: assert property ((LOOP_FILTER_STEP == GCSM_STEP_DOWN &&
        OSC_STAGE_CTRL == 8'h00 && OSC_DIV_CTRL != 4'h0) |=> OSC_STAGE_CTRL == 8'hFF
        && OSC_DIV_CTRL == $past(OSC_DIV_CTRL) - 4'h1) else $error("borrow wrong");
    AST_STEP_IDLE: assert property (LOOP_FILTER_STEP == GCSM_STEP_NONE |=>
        $stable(OSC_STAGE_CTRL) && $stable(OSC_DIV_CTRL)) else $error("idle step moved");
    AST_DIV_RANGE: assert property (OSC_DIV_CTRL <= 4'h9)
        else $error("divider out of range");
    AST_RD_HOLD: assert property (!RD_EN |=> $stable(RD_DATA))
        else $error("read data moved without read");
    AST_IRQ_BITS: assert property (RD_EN && MONITOR_IRQ |=> RD_DATA[7] && RD_DATA[6])
        else $error("interrupt without flag and enable");
    AST_OUT_HIGH: assert property ($rose(OSC_OUT_CLK) |-> s_out_hi)
        else $error("runt high on output clock");
    AST_OUT_LOW: assert property ($fell(OSC_OUT_CLK) |-> s_out_lo)
        else $error("runt low on output clock");
    AST_TB_HIGH: assert property ($rose(TIMEBASE_CLK) |-> s_tb_hi)
        else $error("runt high on timebase clock");
endmodule : gcsm_chk

// *** sim/gcsm_top_test.sv ***
`timescale 1ns/10ps

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end

// ****************************************
// Bench for the clock switch top
// ****************************************
module gcsm_top_test;
    import gcsm_pkg::*;

    logic CLK, SRST, INT_OSC_CLK, EXT_OSC_CLK, INT_CLK_DEAD, EXT_CLK_DEAD;
    logic INT_GEN_STABLE, EXT_GEN_STABLE, WR_EN, RD_EN;
    logic OSC_OUT_CLK, TIMEBASE_CLK, MONITOR_IRQ, int_run, ext_run;
    gcsm_ctrl_t WR_DATA, RD_DATA;
    gcsm_step_t LOOP_FILTER_STEP;
    gcsm_div_t OSC_DIV_CTRL;
    gcsm_stage_t OSC_STAGE_CTRL;
    int n_errors, num_checks;

    gcsm_top u_dut (.CLK, .SRST, .INT_OSC_CLK, .EXT_OSC_CLK, .INT_CLK_DEAD, .EXT_CLK_DEAD,
        .INT_GEN_STABLE, .EXT_GEN_STABLE, .WR_EN, .WR_DATA, .RD_EN, .RD_DATA,
        .LOOP_FILTER_STEP, .OSC_DIV_CTRL, .OSC_STAGE_CTRL, .OSC_OUT_CLK, .TIMEBASE_CLK,
        .MONITOR_IRQ);

    // System clock, 4 ns
    initial begin
        CLK = 1'b0;
        forever #2 CLK = ~CLK;
    end

    // Oscillators stop only when low, so a stopped source never leaves a cut pulse
    initial begin
        INT_OSC_CLK = 1'b0;
        #1;
        forever begin
            #26;
            if (int_run || INT_OSC_CLK) INT_OSC_CLK = ~INT_OSC_CLK;
        end
    end
    // External rate stands for a correctly set slow external configuration
    initial begin
        EXT_OSC_CLK = 1'b0;
        #3;
        forever begin
            #38;
            if (ext_run || EXT_OSC_CLK) EXT_OSC_CLK = ~EXT_OSC_CLK;
        end
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : close_out

    task automatic wr(input gcsm_ctrl_t d);
        @(posedge CLK);
        WR_EN <= 1'b1;
        WR_DATA <= d;
        @(posedge CLK);
        WR_EN <= 1'b0;
    endtask : wr

    task automatic rd(input gcsm_ctrl_t e);
        @(posedge CLK);
        RD_EN <= 1'b1;
        @(posedge CLK);
        RD_EN <= 1'b0;
        #1;
        `CHK("control image", e, RD_DATA)
    endtask : rd

    // Counts rises of both outputs over 380 cycles; internal gives about 29, external 20
    task automatic rate(input logic o_ext, input logic t_ext);
        int ro, rt;
        logic po, pt;
        ro = 0;
        rt = 0;
        repeat (100) @(posedge CLK);
        #1;
        po = OSC_OUT_CLK;
        pt = TIMEBASE_CLK;
        repeat (380) begin
            @(posedge CLK);
            #1;
            if (OSC_OUT_CLK && !po) ro++;
            if (TIMEBASE_CLK && !pt) rt++;
            po = OSC_OUT_CLK;
            pt = TIMEBASE_CLK;
        end
        `CHK("output rate", 1'b1, o_ext ? (ro >= 19 && ro <= 21) : (ro >= 28 && ro <= 31))
        `CHK("timebase rate", 1'b1, t_ext ? (rt >= 19 && rt <= 21) : (rt >= 28 && rt <= 31))
    endtask : rate

    task automatic step(input gcsm_step_t c, input int n, input gcsm_stage_t es,
        input gcsm_div_t ed);
        @(posedge CLK);
        LOOP_FILTER_STEP <= c;
        repeat (n) @(posedge CLK);
        LOOP_FILTER_STEP <= GCSM_STEP_NONE;
        @(posedge CLK);
        #1;
        `CHK("stage control", es, OSC_STAGE_CTRL)
        `CHK("divider control", ed, OSC_DIV_CTRL)
    endtask : step

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        #1;
        `CHK("stage reset", 8'h80, OSC_STAGE_CTRL)
        rd(8'h0C);
        rate(1'b0, 1'b0);
    endtask : t_reset

    task automatic t_refuse();
        wr(8'h10);
        rd(8'h0C);
        wr(8'h28);
        rd(8'h0C);
        wr(8'h88);
        rd(8'h0C);
        wr(8'h00);
        rd(8'h0C);
    endtask : t_refuse

    task automatic t_switch();
        ext_run = 1'b1;
        wr(8'h0A);
        @(posedge CLK);
        EXT_GEN_STABLE <= 1'b1;
        wr(8'h1A);
        wr(8'h12);
        rd(8'h17);
        rate(1'b1, 1'b1);
        wr(8'h1A);
        wr(8'h0A);
        rd(8'h0F);
        rate(1'b0, 1'b1);
        wr(8'h08);
        rd(8'h0D);
        rate(1'b0, 1'b0);
    endtask : t_switch

    task automatic t_monitor();
        wr(8'h0A);
        rd(8'h0F);
        wr(8'hAA);
        rd(8'h2F);
        wr(8'hAA);
        rd(8'hAF);
        @(posedge CLK);
        EXT_GEN_STABLE <= 1'b0;
        rd(8'hAE);
        @(posedge CLK);
        EXT_GEN_STABLE <= 1'b1;
        int_run = 1'b0;
        repeat (30) @(posedge CLK);
        INT_CLK_DEAD <= 1'b1;
        INT_GEN_STABLE <= 1'b0;
        repeat (3) @(posedge CLK);
        rd(8'hFB);
        `CHK("interrupt", 1'b1, MONITOR_IRQ)
        rate(1'b1, 1'b1);
        @(posedge CLK);
        INT_CLK_DEAD <= 1'b0;
        wr(8'hFA);
        rd(8'hFB);
        wr(8'hFA);
        wr(8'hBA);
        rd(8'hFB);
        wr(8'hBA);
        rd(8'hBB);
        `CHK("interrupt", 1'b0, MONITOR_IRQ)
        wr(8'h1A);
        rd(8'h1B);
    endtask : t_monitor

    task automatic t_step();
        step(GCSM_STEP_DOWN, 129, 8'h00, 4'h0);
        step(GCSM_STEP_UP, 256, 8'h00, 4'h1);
        step(GCSM_STEP_UP, 2400, 8'hFF, 4'h9);
        step(GCSM_STEP_DOWN, 256, 8'hFF, 4'h8);
        step(gcsm_step_t'(2'd3), 5, 8'hFF, 4'h8);
    endtask : t_step

    // Watchdog: a hang counts as a mismatch
    initial begin
        #100us;
        n_errors++;
        close_out();
    end

    // Main sequence
    initial begin
        n_errors = 0;
        num_checks = 0;
        SRST = 1'b1;
        int_run = 1'b1;
        ext_run = 1'b0;
        INT_CLK_DEAD = 1'b0;
        EXT_CLK_DEAD = 1'b0;
        INT_GEN_STABLE = 1'b1;
        EXT_GEN_STABLE = 1'b0;
        WR_EN = 1'b0;
        RD_EN = 1'b0;
        WR_DATA = 8'h00;
        LOOP_FILTER_STEP = GCSM_STEP_NONE;
        repeat (2) @(posedge CLK);
        SRST <= 1'b0;
        @(posedge CLK);
        t_reset();
        t_refuse();
        t_switch();
        t_monitor();
        t_step();
        close_out();
    end
endmodule : gcsm_top_test

bind gcsm_top gcsm_chk u_chk (.CLK, .SRST, .RD_EN, .RD_DATA, .LOOP_FILTER_STEP,
    .OSC_DIV_CTRL, .OSC_STAGE_CTRL, .OSC_OUT_CLK, .TIMEBASE_CLK, .MONITOR_IRQ);
